// ==== logic/kbchm_consts.svh ====
// Constants of the keyboard host mailbox: addresses, field positions, reset values and counts.
`ifndef KBCHM_CONSTS_SVH
`define KBCHM_CONSTS_SVH

// ============================================================
// Host I/O addresses
// ============================================================
`define KBCHM_ADDR_DATA 16'h0060
`define KBCHM_ADDR_CMD 16'h0064
`define KBCHM_ADDR_SEL 16'h0004
`define KBCHM_SA2_BIT 2

// ============================================================
// Status register layout and reset
// ============================================================
`define KBCHM_ST_OFULL 0
`define KBCHM_ST_IFULL 1
`define KBCHM_ST_CD 3
`define KBCHM_STATUS_RST 8'h00
`define KBCHM_USER_MASK 8'hF4

// ============================================================
// Port two bits and reset
// ============================================================
`define KBCHM_PORT2_RST 8'h00
`define KBCHM_P2_A20 1
`define KBCHM_P2_MS_DATA 2
`define KBCHM_P2_MS_CLK 3
`define KBCHM_P2_KB_IRQ 4
`define KBCHM_P2_MS_IRQ 5
`define KBCHM_P2_KB_CLK 6
`define KBCHM_P2_KB_DATA 7

// ============================================================
// Synchroniser and timing
// ============================================================
`define KBCHM_SYNC_W 30
`define KBCHM_SYNC_RST 30'h3FFF_FFFF
`define KBCHM_RST_MIN_CYC 24

`endif

// ==== logic/kbchm_pkg.sv ====
// Types shared by the keyboard host mailbox modules.
package kbchm_pkg;

    // ============================================================
    // Status register image, msb first.
    // ============================================================
    typedef struct packed {
        logic [3:0] user_hi;
        logic cd;
        logic user_2;
        logic ifull;
        logic ofull;
    } kbchm_status_type;

    // ============================================================
    // One synchronised view of the host and line pins.
    // ============================================================
    typedef struct packed {
        logic [3:0] line;
        logic wr_n;
        logic rd_n;
        logic [7:0] data;
        logic [15:0] addr;
    } kbchm_pins_type;

    // Power states of the controller core.
    typedef enum logic [1:0] {
        KBCHM_RUN,
        KBCHM_SOFT,
        KBCHM_HARD
    } kbchm_pwr_type;

endpackage

// ==== logic/kbchm_sync.sv ====
// Two-stage synchroniser for every pin that the mailbox samples.
`timescale 1ns/1ps
`include "kbchm_consts.svh"

module kbchm_sync
(
    input wire logic sys_clk_in, // Controller clock.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic [`KBCHM_SYNC_W-1:0] async_in, // Raw pin levels.
    output logic [`KBCHM_SYNC_W-1:0] sync_out // Levels after two flops.
);

    // ============================================================
    // Stages
    // ============================================================
    logic [`KBCHM_SYNC_W-1:0] meta_r;
    logic [`KBCHM_SYNC_W-1:0] sync_r;

    // The first stage feeds only the second; idle pins read as high during reset.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            meta_r <= `KBCHM_SYNC_RST;
            sync_r <= `KBCHM_SYNC_RST;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// ==== logic/kbchm_od_pins.sv ====
// Open-drain drivers for the keyboard and mouse clock and data lines.
`timescale 1ns/1ps
`include "kbchm_consts.svh"

module kbchm_od_pins
(
    input wire logic sys_clk_in, // Controller clock.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic [7:0] port2_in, // Port two image.
    output logic [3:0] line_drive_out, // Level driven: kb clock, kb data, mouse clock, mouse data.
    output logic [3:0] line_oe_out // High while the line is pulled low.
);

    logic [3:0] oe_r;
    logic [3:0] drive_r;

    // ============================================================
    // Per-line mapping
    // ============================================================
    // The pin is the inverted port bit, so a one in the port pulls the line low.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_line
            localparam int SRC = (gi == 0) ? `KBCHM_P2_KB_CLK : (gi == 1) ? `KBCHM_P2_KB_DATA :
                                 (gi == 2) ? `KBCHM_P2_MS_CLK : `KBCHM_P2_MS_DATA;
            logic oe_nxt;
            always_comb
            begin
                oe_nxt = port2_in[SRC]; // R14
            end
            // Lines float high during reset so the external pull-ups win.
            always_ff @(posedge sys_clk_in)
            begin
                if (!rstn_in)
                begin
                    oe_r[gi] <= 1'b0;
                    drive_r[gi] <= 1'b0;
                end
                else
                begin
                    oe_r[gi] <= oe_nxt;
                    drive_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign line_oe_out = oe_r;
    assign line_drive_out = drive_r;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    a_od_line_map: assert property (##1 line_oe_out == $past({port2_in[`KBCHM_P2_MS_DATA], // R14
        port2_in[`KBCHM_P2_MS_CLK], port2_in[`KBCHM_P2_KB_DATA], port2_in[`KBCHM_P2_KB_CLK]}))
        else $error("Line enables do not follow port two.");

endmodule

// ==== logic/kbchm_mailbox.sv ====
// Keyboard controller host mailbox: host port, flags, interrupt gating, pins and power-down.
//
// Contract
// R1 - Data write loads input, clears C/D, sets input-full
// R2 - Command write loads input, sets C/D, input-full
// R3 - Command-address read returns status, data untouched
// R4 - Data read returns output; gated clears flag, interrupt
// R5 - Ungated: firmware clears interrupt and aux flag
// R6 - Host write copies SA2 into C/D
// R7 - Controller output write sets output-full, gated interrupt
// R8 - Controller input read clears input-full and interrupt
// R9 - Gated keyboard interrupt is output-full while port2 bit4
// R10 - Ungated keyboard interrupt follows port2 bit4
// R11 - Gated mouse interrupt: inverted input-full with bit5
// R12 - Ungated mouse interrupt follows port2 bit5
// R13 - Port2 bit1 drives gate A20
// R14 - Inverted port2 bits drive open-drain lines
// R15 - Halt stops ALU until reset or write
// R16 - Write wake calls input-full routine if enabled
// R17 - Reset wake restarts fetch at zero
// R18 - Stop disables oscillator, same wake sources
// R19 - Two core interrupts: input-full, timer overflow
// R20 - Status resets zero, host read-only
// R21 - Status: output-full bit0, input-full bit1, C/D bit3
// R22 - Reset held at least 24 clocks
// R23 - Data read with output-full clear changes nothing
`timescale 1ns/1ps
`include "kbchm_consts.svh"

module kbchm_mailbox
(
    input wire logic sys_clk_in, // Controller clock, 40 MHz.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic [15:0] host_addr_in, // Host I/O address.
    input wire logic [7:0] host_data_in, // Host write data.
    input wire logic host_rd_n_in, // Host I/O read strobe, active low.
    input wire logic host_wr_n_in, // Host I/O write strobe, active low.
    output logic [7:0] host_data_out, // Host read data.
    output logic host_data_oe_out, // High while driving host data.
    output logic keyboard_interrupt_out, // Keyboard interrupt.
    output logic mouse_interrupt_out, // Mouse interrupt.
    output logic gate_a20_out, // Gate A20 output.
    input wire logic [3:0] line_in, // Sensed kb clock, kb data, mouse clock, mouse data.
    output logic [3:0] line_drive_out, // Open-drain drive level.
    output logic [3:0] line_oe_out, // Open-drain enable.
    input wire logic ctl_out_wr_in, // Core writes the output register.
    input wire logic [7:0] ctl_out_data_in, // Core output byte.
    input wire logic ctl_in_rd_in, // Core reads the input register.
    output logic [7:0] controller_input_reg_out, // Input register for the core.
    input wire logic ctl_status_wr_in, // Core writes the status register.
    input wire logic [7:0] ctl_status_data_in, // Core status byte.
    output logic [7:0] ctl_status_out, // Status register for the core.
    input wire logic ctl_en_flags_in, // Core enables flag gating.
    input wire logic ctl_port2_wr_in, // Core writes port two.
    input wire logic [7:0] ctl_port2_data_in, // Port two byte.
    output logic sense_input_zero_out, // Keyboard clock sensed.
    output logic sense_input_one_out, // Mouse clock sensed.
    output logic port1_bit0_out, // Keyboard data sensed.
    output logic port1_bit1_out, // Mouse data sensed.
    input wire logic ctl_halt_in, // Core executes halt.
    input wire logic ctl_stop_in, // Core executes stop.
    input wire logic ctl_ifull_ie_in, // Core input-full interrupt enable.
    input wire logic timer_ovf_in, // Core timer overflow.
    output logic [1:0] core_irq_out, // Core interrupts: timer, input-full.
    output logic alu_clk_en_out, // ALU clock enable.
    output logic osc_en_out, // Oscillator driver enable.
    output logic resume_call_out, // Wake resumes with an interrupt call.
    output logic resume_next_out, // Wake resumes with the next instruction.
    output logic fetch_zero_out // Fetch restarts at address zero.
);

    // ============================================================
    // Pin synchronisation
    // ============================================================
    logic [`KBCHM_SYNC_W-1:0] sync_bits;
    kbchm_pkg::kbchm_pins_type pins;

    kbchm_sync u_sync
    (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in({line_in, host_wr_n_in, host_rd_n_in, host_data_in, host_addr_in}),
        .sync_out(sync_bits)
    );

    assign pins = kbchm_pkg::kbchm_pins_type'(sync_bits);

    // ============================================================
    // Host cycle detection
    // ============================================================
    logic wr_prev_r;
    logic rd_prev_r;
    logic wr_prev_nxt;
    logic rd_prev_nxt;
    kbchm_pkg::kbchm_pins_type cap_r;
    kbchm_pkg::kbchm_pins_type cap_nxt;
    logic cap_hit;
    logic cap_sa2;
    logic wr_evt;
    logic rd_evt;
    logic live_hit;

    // Address and data are captured while a strobe is low, because ISA may move them right at the end.
    always_comb
    begin
        wr_prev_nxt = pins.wr_n;
        rd_prev_nxt = pins.rd_n;
        cap_nxt = cap_r;
        if (!pins.wr_n || !pins.rd_n)
        begin
            cap_nxt = pins;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b1;
            cap_r <= kbchm_pkg::kbchm_pins_type'(`KBCHM_SYNC_RST);
        end
        else
        begin
            wr_prev_r <= wr_prev_nxt;
            rd_prev_r <= rd_prev_nxt;
            cap_r <= cap_nxt;
        end
    end

    // A cycle is acted on at the release of its strobe.
    assign cap_hit = (cap_r.addr & ~`KBCHM_ADDR_SEL) == `KBCHM_ADDR_DATA;
    assign cap_sa2 = cap_r.addr[`KBCHM_SA2_BIT];
    assign wr_evt = !wr_prev_r && pins.wr_n && cap_hit;
    assign rd_evt = !rd_prev_r && pins.rd_n && cap_hit;
    assign live_hit = (pins.addr & ~`KBCHM_ADDR_SEL) == `KBCHM_ADDR_DATA;

    // ============================================================
    // Mailbox registers and flags
    // ============================================================
    kbchm_pkg::kbchm_status_type status_r; // R21
    kbchm_pkg::kbchm_status_type status_nxt;
    logic [7:0] in_data_r;
    logic [7:0] in_data_nxt;
    logic [7:0] out_data_r;
    logic [7:0] out_data_nxt;
    logic en_flags_r;
    logic en_flags_nxt;
    logic [7:0] port2_r;
    logic [7:0] port2_nxt;

    // Hardware sets are applied last so a set in the same cycle as a clear wins.
    always_comb
    begin
        status_nxt = status_r;
        in_data_nxt = in_data_r;
        out_data_nxt = out_data_r;
        en_flags_nxt = en_flags_r | ctl_en_flags_in;
        port2_nxt = ctl_port2_wr_in ? ctl_port2_data_in : port2_r;
        if (ctl_status_wr_in)
        begin
            status_nxt = kbchm_pkg::kbchm_status_type'((status_r & ~`KBCHM_USER_MASK) |
                                                       (ctl_status_data_in & `KBCHM_USER_MASK)); // R20
            // Without gating, firmware clears the output-full indication itself.
            if (!en_flags_r && !ctl_status_data_in[`KBCHM_ST_OFULL])
            begin
                status_nxt.ofull = 1'b0; // R5
            end
        end
        if (ctl_in_rd_in)
        begin
            status_nxt.ifull = 1'b0; // R8
        end
        if (rd_evt && !cap_sa2 && en_flags_r)
        begin
            status_nxt.ofull = 1'b0; // R4
        end
        if (ctl_out_wr_in)
        begin
            out_data_nxt = ctl_out_data_in;
            status_nxt.ofull = 1'b1; // R7
        end
        if (wr_evt)
        begin
            in_data_nxt = cap_r.data; // R1 R2
            status_nxt.ifull = 1'b1; // R1 R2
            status_nxt.cd = cap_sa2; // R6
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            status_r <= kbchm_pkg::kbchm_status_type'(`KBCHM_STATUS_RST); // R20
            in_data_r <= 8'h00;
            out_data_r <= 8'h00;
            en_flags_r <= 1'b0;
            port2_r <= `KBCHM_PORT2_RST;
        end
        else
        begin
            status_r <= status_nxt;
            in_data_r <= in_data_nxt;
            out_data_r <= out_data_nxt;
            en_flags_r <= en_flags_nxt;
            port2_r <= port2_nxt;
        end
    end

    // ============================================================
    // Registered outputs
    // ============================================================
    logic [7:0] hdata_r;
    logic hoe_r;
    logic kb_irq_r;
    logic ms_irq_r;
    logic a20_r;
    logic [7:0] cin_r;
    logic [7:0] cst_r;
    logic [3:0] sense_r;
    logic [1:0] irq_r;
    logic [7:0] hdata_nxt;
    logic hoe_nxt;
    logic kb_irq_nxt;
    logic ms_irq_nxt;

    // Interrupts are computed from next values so they move in the same cycle as the flags.
    always_comb
    begin
        hoe_nxt = !pins.rd_n && live_hit;
        hdata_nxt = pins.addr[`KBCHM_SA2_BIT] ? status_r : out_data_r; // R3 R4 R23
        if (en_flags_nxt)
        begin
            kb_irq_nxt = port2_nxt[`KBCHM_P2_KB_IRQ] & status_nxt.ofull; // R9
            ms_irq_nxt = port2_nxt[`KBCHM_P2_MS_IRQ] & ~status_nxt.ifull; // R11
        end
        else
        begin
            kb_irq_nxt = port2_nxt[`KBCHM_P2_KB_IRQ]; // R10
            ms_irq_nxt = port2_nxt[`KBCHM_P2_MS_IRQ]; // R12
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            hdata_r <= 8'h00;
            hoe_r <= 1'b0;
            kb_irq_r <= 1'b0;
            ms_irq_r <= 1'b0;
            a20_r <= 1'b0;
            cin_r <= 8'h00;
            cst_r <= `KBCHM_STATUS_RST;
            sense_r <= 4'hF;
            irq_r <= 2'h0;
        end
        else
        begin
            hdata_r <= hdata_nxt;
            hoe_r <= hoe_nxt;
            kb_irq_r <= kb_irq_nxt;
            ms_irq_r <= ms_irq_nxt;
            a20_r <= port2_nxt[`KBCHM_P2_A20]; // R13
            cin_r <= in_data_nxt;
            cst_r <= status_nxt;
            sense_r <= pins.line; // R14
            irq_r <= {timer_ovf_in, status_nxt.ifull}; // R19
        end
    end

    assign host_data_out = hdata_r;
    assign host_data_oe_out = hoe_r;
    assign keyboard_interrupt_out = kb_irq_r;
    assign mouse_interrupt_out = ms_irq_r;
    assign gate_a20_out = a20_r;
    assign controller_input_reg_out = cin_r;
    assign ctl_status_out = cst_r;
    assign sense_input_zero_out = sense_r[0];
    assign port1_bit0_out = sense_r[1];
    assign sense_input_one_out = sense_r[2];
    assign port1_bit1_out = sense_r[3];
    assign core_irq_out = irq_r;

    kbchm_od_pins u_pins
    (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .port2_in(port2_r),
        .line_drive_out(line_drive_out),
        .line_oe_out(line_oe_out)
    );

    // ============================================================
    // Power-down control
    // ============================================================
    kbchm_pkg::kbchm_pwr_type pwr_r;
    kbchm_pkg::kbchm_pwr_type pwr_nxt;
    logic alu_en_r;
    logic osc_en_r;
    logic call_r;
    logic next_r;
    logic fz_r;
    logic call_nxt;
    logic next_nxt;

    // Only a host write wakes the core; reset wakes it through the reset branch.
    always_comb
    begin
        pwr_nxt = pwr_r;
        call_nxt = 1'b0;
        next_nxt = 1'b0;
        case (pwr_r)
            kbchm_pkg::KBCHM_RUN:
            begin
                if (ctl_stop_in)
                begin
                    pwr_nxt = kbchm_pkg::KBCHM_HARD; // R18
                end
                else if (ctl_halt_in)
                begin
                    pwr_nxt = kbchm_pkg::KBCHM_SOFT; // R15
                end
            end
            kbchm_pkg::KBCHM_SOFT, kbchm_pkg::KBCHM_HARD:
            begin
                if (wr_evt)
                begin
                    pwr_nxt = kbchm_pkg::KBCHM_RUN; // R15 R18
                    call_nxt = ctl_ifull_ie_in; // R16
                    next_nxt = !ctl_ifull_ie_in; // R16
                end
            end
            default:
            begin
                pwr_nxt = kbchm_pkg::KBCHM_RUN;
            end
        endcase
    end

    // Reset restarts the oscillator; the holder of reset must cover its start-up time.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            pwr_r <= kbchm_pkg::KBCHM_RUN; // R17 R18
            alu_en_r <= 1'b1;
            osc_en_r <= 1'b1;
            call_r <= 1'b0;
            next_r <= 1'b0;
            fz_r <= 1'b1; // R17
        end
        else
        begin
            pwr_r <= pwr_nxt;
            alu_en_r <= pwr_nxt == kbchm_pkg::KBCHM_RUN;
            osc_en_r <= pwr_nxt != kbchm_pkg::KBCHM_HARD;
            call_r <= call_nxt;
            next_r <= next_nxt;
            fz_r <= 1'b0;
        end
    end

    assign alu_clk_en_out = alu_en_r;
    assign osc_en_out = osc_en_r;
    assign resume_call_out = call_r;
    assign resume_next_out = next_r;
    assign fetch_zero_out = fz_r;

    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_data_wr;
        wr_evt && !cap_sa2;
    endsequence
    sequence s_cmd_wr;
        wr_evt && cap_sa2;
    endsequence
    sequence s_asleep_wake;
        pwr_r != kbchm_pkg::KBCHM_RUN ##0 wr_evt;
    endsequence

    a_data_write: assert property (s_data_wr |=> status_r.ifull && !status_r.cd && // R1
        in_data_r == $past(cap_r.data))
        else $error("Data write did not load input with C/D clear.");
    a_cmd_write: assert property (s_cmd_wr |=> status_r.ifull && status_r.cd && // R2
        in_data_r == $past(cap_r.data))
        else $error("Command write did not load input with C/D set.");
    a_status_read: assert property (!pins.rd_n && pins.addr == `KBCHM_ADDR_CMD |=> // R3
        host_data_oe_out && host_data_out == $past(status_r))
        else $error("Command-address read did not return status.");
    a_read_clear: assert property (rd_evt && !cap_sa2 && en_flags_r && !ctl_out_wr_in |=> // R4
        !status_r.ofull && !keyboard_interrupt_out)
        else $error("Gated data read did not clear output-full.");
    a_read_empty: assert property (rd_evt && !status_r.ofull && !ctl_out_wr_in && !wr_evt && // R23
        !ctl_in_rd_in && !ctl_status_wr_in |=> $stable(status_r))
        else $error("Read with output-full clear changed a flag.");
    a_core_write: assert property (ctl_out_wr_in |=> status_r.ofull && // R7
        out_data_r == $past(ctl_out_data_in))
        else $error("Controller write did not set output-full.");
    a_core_read: assert property (ctl_in_rd_in && !wr_evt |=> !status_r.ifull && !core_irq_out[0]) // R8
        else $error("Controller read did not clear input-full.");
    a_kb_irq_map: assert property (keyboard_interrupt_out == (port2_r[`KBCHM_P2_KB_IRQ] && // R9 R10
        (!en_flags_r || status_r.ofull)))
        else $error("Keyboard interrupt mapping wrong.");
    a_ms_irq_map: assert property (mouse_interrupt_out == (port2_r[`KBCHM_P2_MS_IRQ] && // R11 R12
        (!en_flags_r || !status_r.ifull)))
        else $error("Mouse interrupt mapping wrong.");
    a_a20_follow: assert property (ctl_port2_wr_in |=> gate_a20_out == $past(ctl_port2_data_in[1])) // R13
        else $error("Gate A20 does not follow port two.");
    a_halt_entry: assert property (pwr_r == kbchm_pkg::KBCHM_RUN && ctl_halt_in && !ctl_stop_in |=> // R15
        !alu_clk_en_out && osc_en_out)
        else $error("Halt did not stop only the ALU.");
    a_wake_resume: assert property (s_asleep_wake |=> alu_clk_en_out && osc_en_out && // R16
        resume_call_out == $past(ctl_ifull_ie_in) && resume_next_out != $past(ctl_ifull_ie_in))
        else $error("Wake did not resume correctly.");
    a_stop_osc: assert property (pwr_r == kbchm_pkg::KBCHM_RUN && ctl_stop_in |=> // R18
        !osc_en_out [*1] ##0 !alu_clk_en_out)
        else $error("Stop did not disable the oscillator.");
    a_timer_irq: assert property (##1 core_irq_out[1] == $past(timer_ovf_in)) // R19
        else $error("Timer overflow interrupt not forwarded.");

endmodule

// ==== dv/kbchm_line_model.sv ====
// Keyboard and mouse line model: pulled-up open-drain wires.
`timescale 1ns/1ps

module kbchm_line_model
(
    input wire logic [3:0] line_oe_in, // Mailbox pulls the line low.
    output logic [3:0] line_out // Resolved wire levels.
);
    // ============================================================
    // Wire resolution
    // ============================================================
    // A released line floats back high through its pull-up.
    assign line_out = ~line_oe_in;
endmodule

// ==== dv/kbc_host_mailbox_tb.sv ====
// Self-checking bench of the keyboard host mailbox.
`timescale 1ns/1ps

module kbc_host_mailbox_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] hd = 8'h00;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic ow = 1'b0, ir = 1'b0, sw = 1'b0, ef = 1'b0, pw = 1'b0, hl = 1'b0, st = 1'b0, ie = 1'b1, tov = 1'b0;
    logic [7:0] od = 8'h00, sd = 8'h00, pd = 8'h00;
    logic [7:0] hq, inr, stat;
    logic [3:0] ldr, loe, lines;
    logic ki, mi, a20, s0, s1, b0, b1, alu, osc, rc, rnx, fz, hoe;
    logic [1:0] wake_seen = 2'b00;
    logic [1:0] cirq;
    int num_errors = 0;
    int num_checks = 0;

    // ============================================================
    // Clock, design and line model
    // ============================================================
    // The period is 25 ns, one half period per inversion.
    always #12.5 clk = ~clk;
    kbchm_mailbox kbchm_mailbox_inst (.sys_clk_in(clk), .rstn_in(rstn), .host_addr_in(addr), .host_data_in(hd),
        .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_data_out(hq), .host_data_oe_out(hoe),
        .keyboard_interrupt_out(ki), .mouse_interrupt_out(mi), .gate_a20_out(a20), .line_in(lines),
        .line_drive_out(ldr), .line_oe_out(loe), .ctl_out_wr_in(ow), .ctl_out_data_in(od), .ctl_in_rd_in(ir),
        .controller_input_reg_out(inr), .ctl_status_wr_in(sw), .ctl_status_data_in(sd), .ctl_status_out(stat),
        .ctl_en_flags_in(ef), .ctl_port2_wr_in(pw), .ctl_port2_data_in(pd), .sense_input_zero_out(s0),
        .sense_input_one_out(s1), .port1_bit0_out(b0), .port1_bit1_out(b1), .ctl_halt_in(hl), .ctl_stop_in(st),
        .ctl_ifull_ie_in(ie), .timer_ovf_in(tov), .core_irq_out(cirq), .alu_clk_en_out(alu), .osc_en_out(osc),
        .resume_call_out(rc), .resume_next_out(rnx), .fetch_zero_out(fz));
    kbchm_line_model kbchm_line_model_inst (.line_oe_in(loe), .line_out(lines));
    // Resume pulses last one cycle, so they are latched; gated by reset to keep unknowns out.
    always @(posedge clk) if (rstn) wake_seen <= wake_seen | {rc, rnx};

    // ============================================================
    // Tasks
    // ============================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Host cycles keep each strobe well past the three-cycle minimum on both phases.
    task automatic hw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) {addr, hd, wr_n} <= {a, d, 1'b0};
        repeat (4) @(posedge clk);
        wr_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic hr(input logic [15:0] a, output logic [7:0] q);
        @(posedge clk) {addr, rd_n} <= {a, 1'b0};
        repeat (5) @(posedge clk);
        #1 q = hq;
        chk(hoe, 1'b1);
        @(posedge clk) rd_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic p2(input logic [7:0] v);
        @(posedge clk) {pd, pw} <= {v, 1'b1};
        @(posedge clk) pw <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic tick(); repeat (2) @(posedge clk); #1; endtask

    // ============================================================
    // Watchdog and main sequence
    // ============================================================
    // The sequence needs well under two thousand cycles.
    initial
    begin
        #(25 * 20000);
        num_errors++;
        finish_test();
    end
    initial
    begin
        logic [7:0] q;
        repeat (24) @(posedge clk);
        rstn <= 1'b1;
        tick(); tick();
        chk(stat, 8'h00);
        chk(fz, 1'b0);
        hw(16'h0060, 8'hA5);
        chk(stat, 8'h02);
        chk(inr, 8'hA5);
        chk(cirq[0], 1'b1);
        hw(16'h0064, 8'h3C);
        chk(stat, 8'h0A);
        chk(inr, 8'h3C);
        @(posedge clk) ir <= 1'b1; @(posedge clk) ir <= 1'b0; tick();
        chk({stat, 7'h00, cirq[0]}, 16'h0800);
        hr(16'h0064, q);
        chk(q, 8'h08);
        chk({hoe, inr}, 16'h003C);
        p2(8'h46);
        chk({ldr, a20, loe}, 16'h0019);
        chk({b1, s1, b0, s0}, 4'h6);
        p2(8'h30);
        chk({ki, mi, a20}, 3'h6);
        @(posedge clk) {od, ow} <= {8'h77, 1'b1}; @(posedge clk) ow <= 1'b0; tick();
        hr(16'h0060, q);
        chk({q, stat}, 16'h7709);
        @(posedge clk) {sd, sw} <= {8'h00, 1'b1}; @(posedge clk) sw <= 1'b0; tick();
        chk({stat, 7'h00, ki}, 16'h0801);
        @(posedge clk) ef <= 1'b1; @(posedge clk) ef <= 1'b0; tick();
        chk({ki, mi}, 2'h1);
        @(posedge clk) {od, ow} <= {8'h5A, 1'b1}; @(posedge clk) ow <= 1'b0; tick();
        chk({stat, 7'h00, ki}, 16'h0901);
        hr(16'h0060, q);
        chk(q, 8'h5A);
        chk({stat, 7'h00, ki}, 16'h0800);
        hr(16'h0060, q);
        chk({q, stat}, 16'h5A08);
        hw(16'h0060, 8'h11);
        chk({stat, 7'h00, mi}, 16'h0200);
        @(posedge clk) hl <= 1'b1; @(posedge clk) hl <= 1'b0; tick();
        chk(alu, 1'b0);
        hw(16'h0064, 8'h22);
        chk(alu, 1'b1);
        chk(wake_seen, 2'b10);
        @(posedge clk) {st, ie} <= 2'b10; @(posedge clk) st <= 1'b0; tick();
        chk({osc, alu}, 2'h0);
        hw(16'h0060, 8'h33);
        chk({osc, alu}, 2'h3);
        chk(wake_seen, 2'b11);
        // Halt again, then wake by a mid-run reset.
        @(posedge clk) hl <= 1'b1; @(posedge clk) {hl, rstn} <= 2'b00;
        repeat (24) @(posedge clk);
        #1 chk({alu, osc, fz, stat}, 16'h0700);
        @(posedge clk) rstn <= 1'b1; tick();
        chk({fz, stat}, 16'h0000);
        finish_test();
    end
endmodule
